// ### hdl/speed_trip_regs.vh
`ifndef SPEED_TRIP_REGS_VH
`define SPEED_TRIP_REGS_VH

// clock rate and millisecond count
`define STR_CLK_HZ       50000000
`define STR_CYC_PER_MS   50000

// register offsets (byte addresses)
`define STR_CTRL_OFS     4'h0
`define STR_TRIP_OFS     4'h4
`define STR_STAT_OFS     4'h8
`define STR_EDGE_OFS     4'hC

// control register fields
`define STR_MODE_LSB     0
`define STR_MODE_MSB     2
`define STR_RESP_LSB     4
`define STR_RESP_MSB     7
`define STR_OFFS_LSB     8
`define STR_OFFS_MSB     11
`define STR_HYST_LSB     12
`define STR_HYST_MSB     15

// reset values
`define STR_CTRL_RST     16'h0000
`define STR_TRIP_RST     18'h003E8

// response steps in milliseconds
`define STR_RESP_MS0     14'h0005
`define STR_RESP_MS1     14'h000A
`define STR_RESP_MS2     14'h0014
`define STR_RESP_MS3     14'h0032
`define STR_RESP_MS4     14'h0064
`define STR_RESP_MS5     14'h00C8
`define STR_RESP_MS6     14'h01F4
`define STR_RESP_MS7     14'h03E8
`define STR_RESP_MS8     14'h1388
`define STR_RESP_MS9     14'h2710

// status register bits
`define STR_ST_RELAY     0
`define STR_ST_LATCH     1
`define STR_ST_ARMED     2
`define STR_ST_VALID     3

// operation modes
`define STR_M_OVER       3'h0
`define STR_M_OVER_L     3'h1
`define STR_M_UNDER      3'h2
`define STR_M_UNDER_L    3'h3
`define STR_M_UNDER_I    3'h4
`define STR_M_UNDER_IL   3'h5

// fractions are in units of 0.01 percent
`define STR_FRAC_ONE     16'h2710

`endif

// ### hdl/speed_trip_relay.v
// Summary of operation
// - input led follows each input cycle
// - relay led lit exactly while tripped
// - overspeed trips above trip point
// - overspeed releases below release point
// - underspeed trips below trip point
// - underspeed releases above release point
// - inhibit modes wait for normal speed first
// - count falling edges, average over interval
// - decide once per response time, plus period
// - overspeed trip point is frequency plus offset
// - underspeed trip point is frequency minus offset
// - no hysteresis: release equals trip point
// - overspeed release is trip minus hysteresis
// - underspeed release is trip plus hysteresis
// - override low forces relay released
// - override high resumes from measured frequency
// - latch reset only in latching modes
// - latching modes hold trip after recovery
// - latch clears by reset in release region
// - latch reset ignored in trip region
// - six selectable output modes
// - ten response steps, 5 ms to 10 s
// - nine offset/hysteresis steps or zero
// - control inputs active low, fast response
`timescale 1ns/10ps
`include "speed_trip_regs.vh"

module speed_trip_relay #(
	parameter CLK_HZ     = `STR_CLK_HZ,
	parameter CYC_PER_MS = `STR_CYC_PER_MS
) (
	input  wire        ref_clk,
	input  wire        nrst,
	input  wire        clk_en,
	input  wire        pulse_in,
	input  wire        override_n,
	input  wire        latch_rst_n,
	input  wire [3:0]  bus_addr,
	input  wire [31:0] bus_wdata,
	input  wire        bus_wr,
	input  wire        bus_rd,
	output reg  [31:0] bus_rdata,
	output wire        relay_out,
	output reg         led_input,
	output wire        led_relay
);

	// frequency in tenths of hertz against a factor scale:
	// edges * clk * 10 * 10000 against trip * factor * cycles,
	// so no divider is needed; 64 bits cover 10 s windows
	localparam [63:0] F_SCALE = CLK_HZ * 64'd100000;

	// response step to milliseconds, ten steps
	function [13:0] resp_ms;
		input [3:0] step;
		begin
			case (step)
				4'h0:    resp_ms = `STR_RESP_MS0;
				4'h1:    resp_ms = `STR_RESP_MS1;
				4'h2:    resp_ms = `STR_RESP_MS2;
				4'h3:    resp_ms = `STR_RESP_MS3;
				4'h4:    resp_ms = `STR_RESP_MS4;
				4'h5:    resp_ms = `STR_RESP_MS5;
				4'h6:    resp_ms = `STR_RESP_MS6;
				4'h7:    resp_ms = `STR_RESP_MS7;
				4'h8:    resp_ms = `STR_RESP_MS8;
				default: resp_ms = `STR_RESP_MS9;
			endcase
		end
	endfunction

	// fraction step to hundredths of a percent, zero disables
	function [15:0] frac_bp;
		input [3:0] step;
		begin
			case (step)
				4'h1:    frac_bp = 16'h0019;
				4'h2:    frac_bp = 16'h0032;
				4'h3:    frac_bp = 16'h0064;
				4'h4:    frac_bp = 16'h00C8;
				4'h5:    frac_bp = 16'h01F4;
				4'h6:    frac_bp = 16'h03E8;
				4'h7:    frac_bp = 16'h07D0;
				4'h8:    frac_bp = 16'h09C4;
				4'h9:    frac_bp = 16'h0D05;
				default: frac_bp = 16'h0000;
			endcase
		end
	endfunction

	// mode to {inhibit, latch, under}, unused codes act as overspeed
	// one decode feeds every mode-dependent path
	function [2:0] mode_class;
		input [2:0] m;
		begin
			case (m)
				`STR_M_OVER_L:   mode_class = 3'h2;
				`STR_M_UNDER:    mode_class = 3'h1;
				`STR_M_UNDER_L:  mode_class = 3'h3;
				`STR_M_UNDER_I:  mode_class = 3'h5;
				`STR_M_UNDER_IL: mode_class = 3'h7;
				default:         mode_class = 3'h0;
			endcase
		end
	endfunction

	// software settings
	reg  [15:0] ctrl_q;
	reg  [17:0] trip_q;
	reg  [15:0] ctrl_d;
	reg  [17:0] trip_d;
	reg  [31:0] rdata_d;

	// pin inputs, synchronised, and edge history
	wire [2:0]  pin_raw;
	wire [2:0]  pin_s;
	reg         pul_prev_q;
	reg         ovr_prev_q;

	// measurement window
	reg  [31:0] win_cnt_q;
	reg  [31:0] edge_cnt_q;
	reg  [31:0] meas_edges_q;
	reg  [31:0] meas_cyc_q;
	reg         meas_new_q;
	reg         valid_q;
	reg  [31:0] win_cnt_d;
	reg  [31:0] edge_cnt_d;
	reg  [31:0] meas_edges_d;
	reg  [31:0] meas_cyc_d;
	reg         valid_d;

	// relay decision
	reg         tripped_q;
	reg         latched_q;
	reg         armed_q;
	reg         tripped_d;
	reg         latched_d;
	reg         armed_d;

	wire [2:0]  mode;
	wire [2:0]  mode_cls;
	wire [3:0]  resp_step;
	wire        under;
	wire        latch_md;
	wire        inhib_md;
	wire        pul_s;
	wire        ovr_s;
	wire        lrs_s;
	wire        fall;
	wire        ovr_rise;
	wire [31:0] min_cyc;
	wire [31:0] max_cyc;
	wire        win_done;
	wire [15:0] off_bp;
	wire [15:0] hys_bp;
	reg  [15:0] trip_fac;
	reg  [15:0] rel_fac;
	wire [63:0] f_lhs;
	wire [63:0] trip_rhs;
	wire [63:0] rel_rhs;
	reg         trip_rgn;
	reg         rel_rgn;
	wire        eval;

	// mode decode
	assign mode      = ctrl_q[`STR_MODE_MSB:`STR_MODE_LSB];
	assign resp_step = ctrl_q[`STR_RESP_MSB:`STR_RESP_LSB];
	assign mode_cls  = mode_class(mode);
	assign under     = mode_cls[0];
	assign latch_md  = mode_cls[1];
	assign inhib_md  = mode_cls[2];

	// two flip-flops on every pin input, buttons idle high
	// a metastable first stage is never read by logic
	assign pin_raw = {latch_rst_n, override_n, pulse_in};
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_sync
			reg [1:0] sync_q;
			always @(posedge ref_clk) begin
				if (!nrst)
					sync_q <= (g == 0) ? 2'h0 : 2'h3;
				else if (clk_en)
					sync_q <= {sync_q[0], pin_raw[g]};
			end
			assign pin_s[g] = sync_q[1];
		end
	endgenerate

	// edge history, reset to idle levels so no false edge
	always @(posedge ref_clk) begin
		if (!nrst) begin
			pul_prev_q <= 1'b0;
			ovr_prev_q <= 1'b1;
			led_input  <= 1'b0;
		end else if (clk_en) begin
			pul_prev_q <= pul_s;
			ovr_prev_q <= ovr_s;
			led_input  <= pul_s;
		end
	end

	assign pul_s    = pin_s[0];
	assign ovr_s    = pin_s[1];
	assign lrs_s    = pin_s[2];
	assign fall     = pul_prev_q & ~pul_s;
	assign ovr_rise = ovr_s & ~ovr_prev_q;

	// window length from the response step
	assign min_cyc = resp_ms(resp_step) * CYC_PER_MS;
	assign max_cyc = {min_cyc[30:0], 1'b0};
	// window closes on first falling edge past the minimum
	// a dead input times out at twice the minimum, reads 0 Hz
	assign win_done = (win_cnt_q >= min_cyc - 32'h1) &
	                  (fall | (win_cnt_q >= max_cyc - 32'h1));

	// next window state, capture on window close
	always @* begin
		win_cnt_d    = win_cnt_q + 32'h1;
		edge_cnt_d   = edge_cnt_q + {31'h0, fall};
		meas_edges_d = meas_edges_q;
		meas_cyc_d   = meas_cyc_q;
		valid_d      = valid_q;
		if (win_done) begin
			meas_edges_d = edge_cnt_d;
			meas_cyc_d   = win_cnt_d;
			win_cnt_d    = 32'h0;
			edge_cnt_d   = 32'h0;
			valid_d      = 1'b1;
		end
	end

	// measurement registers
	always @(posedge ref_clk) begin
		if (!nrst) begin
			win_cnt_q    <= 32'h0;
			edge_cnt_q   <= 32'h0;
			meas_edges_q <= 32'h0;
			meas_cyc_q   <= 32'h1;
			meas_new_q   <= 1'b0;
			valid_q      <= 1'b0;
		end else if (clk_en) begin
			win_cnt_q    <= win_cnt_d;
			edge_cnt_q   <= edge_cnt_d;
			meas_edges_q <= meas_edges_d;
			meas_cyc_q   <= meas_cyc_d;
			meas_new_q   <= win_done;
			valid_q      <= valid_d;
		end
	end

	// trip and release points as factors of the trip frequency
	// release factor sits one hysteresis step on the safe side
	assign off_bp = frac_bp(ctrl_q[`STR_OFFS_MSB:`STR_OFFS_LSB]);
	assign hys_bp = frac_bp(ctrl_q[`STR_HYST_MSB:`STR_HYST_LSB]);

	always @* begin
		if (under) begin
			trip_fac = `STR_FRAC_ONE - off_bp;
			rel_fac  = trip_fac + hys_bp;
		end else begin
			trip_fac = `STR_FRAC_ONE + off_bp;
			rel_fac  = trip_fac - hys_bp;
		end
	end

	// average frequency compared without division
	// strict compares: exactly on a point neither trips nor releases
	assign f_lhs    = meas_edges_q * F_SCALE;
	assign trip_rhs = trip_q * trip_fac * meas_cyc_q;
	assign rel_rhs  = trip_q * rel_fac * meas_cyc_q;

	always @* begin
		if (under) begin
			trip_rgn = f_lhs < trip_rhs;
			rel_rgn  = f_lhs > rel_rhs;
		end else begin
			trip_rgn = f_lhs > trip_rhs;
			rel_rgn  = f_lhs < rel_rhs;
		end
	end

	// new measurement or override release triggers a decision
	// deciding only at window close or override release keeps one per response time
	assign eval = meas_new_q | ovr_rise;

	// next relay state, override above trip above latch
	// latch reset is a level, honoured in any cycle
	always @* begin
		tripped_d = tripped_q;
		latched_d = latched_q;
		armed_d   = armed_q;
		if (meas_new_q & rel_rgn)
			armed_d = 1'b1;
		if (!valid_q) begin
			tripped_d = 1'b0;
			latched_d = 1'b0;
		end else if (!ovr_s) begin
			tripped_d = 1'b0;
			latched_d = 1'b0;
		end else if (eval & trip_rgn & (armed_q | ~inhib_md)) begin
			tripped_d = 1'b1;
			latched_d = latch_md;
		end else if (latched_q) begin
			if (latch_md & ~lrs_s & rel_rgn) begin
				tripped_d = 1'b0;
				latched_d = 1'b0;
			end
			if (!latch_md)
				latched_d = 1'b0;
		end else if (eval & rel_rgn) begin
			tripped_d = 1'b0;
		end
	end

	// relay state registers
	always @(posedge ref_clk) begin
		if (!nrst) begin
			tripped_q <= 1'b0;
			latched_q <= 1'b0;
			armed_q   <= 1'b0;
		end else if (clk_en) begin
			tripped_q <= tripped_d;
			latched_q <= latched_d;
			armed_q   <= armed_d;
		end
	end

	assign relay_out = tripped_q;
	assign led_relay = tripped_q;

	// register write decode
	always @* begin
		ctrl_d = ctrl_q;
		trip_d = trip_q;
		if (bus_wr & (bus_addr == `STR_CTRL_OFS))
			ctrl_d = bus_wdata[15:0];
		if (bus_wr & (bus_addr == `STR_TRIP_OFS))
			trip_d = bus_wdata[17:0];
	end

	// software settings, writes ignored while frozen
	always @(posedge ref_clk) begin
		if (!nrst) begin
			ctrl_q <= `STR_CTRL_RST;
			trip_q <= `STR_TRIP_RST;
		end else if (clk_en) begin
			ctrl_q <= ctrl_d;
			trip_q <= trip_d;
		end
	end

	// read mux, zero outside a read so stale data never shows
	always @* begin
		rdata_d = 32'h0;
		if (bus_rd) begin
			case (bus_addr)
				`STR_CTRL_OFS: rdata_d = {16'h0, ctrl_q};
				`STR_TRIP_OFS: rdata_d = {14'h0, trip_q};
				`STR_STAT_OFS: rdata_d = {28'h0, valid_q,
				                armed_q, latched_q, tripped_q};
				`STR_EDGE_OFS: rdata_d = meas_edges_q;
				default:       rdata_d = 32'h0;
			endcase
		end
	end

	// read data register, valid the cycle after the strobe
	always @(posedge ref_clk) begin
		if (!nrst)
			bus_rdata <= 32'h0;
		else if (clk_en)
			bus_rdata <= rdata_d;
	end

endmodule

// ### dv/speed_trip_monitor.sv
`timescale 1ns/10ps
module speed_trip_monitor (
	input wire        ref_clk,
	input wire        nrst,
	input wire        clk_en,
	input wire        pulse_in,
	input wire        override_n,
	input wire        bus_rd,
	input wire [31:0] bus_rdata,
	input wire        relay_out,
	input wire        led_input,
	input wire        led_relay
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// indicators and override
	property p_led; relay_out == led_relay; endproperty
	a_led: assert property (p_led)
		else $error("relay led differs");
	property p_ovr; (!override_n && clk_en)[*4] |-> !relay_out; endproperty
	a_ovr: assert property (p_ovr)
		else $error("relay on under override");
	property p_rise; $rose(relay_out) |-> $past(override_n, 3); endproperty
	a_rise: assert property (p_rise)
		else $error("relay rose after override");
	property p_in1; (pulse_in && clk_en)[*4] |-> led_input; endproperty
	a_in1: assert property (p_in1)
		else $error("input led stuck low");
	property p_in0; (!pulse_in && clk_en)[*4] |-> !led_input; endproperty
	a_in0: assert property (p_in0)
		else $error("input led stuck high");
	// startup, bus and freeze
	property p_rst; $rose(nrst) |-> (!relay_out)[*3]; endproperty
	a_rst: assert property (p_rst)
		else $error("relay on after reset");
	property p_rd; !$past(bus_rd) && $past(clk_en) |-> bus_rdata == 32'h0;
	endproperty
	a_rd: assert property (p_rd)
		else $error("read data without read");
	property p_frz; !$past(clk_en) |-> $stable(relay_out); endproperty
	a_frz: assert property (p_frz)
		else $error("relay moved while frozen");
endmodule

// ### dv/pulse_src.sv
`timescale 1ns/10ps
// sensor pulse source, period in clocks
module pulse_src (
	input  wire       ref_clk,
	input  wire [7:0] period,
	output reg        pulse
);
	reg [7:0] cnt_q;
	initial begin
		cnt_q = 8'h00;
		pulse = 1'b0;
	end
	// high first half, falling edge each period
	always @(posedge ref_clk) begin
		cnt_q <= (cnt_q + 8'h01 >= period) ? 8'h00 : cnt_q + 8'h01;
		pulse <= cnt_q < {1'b0, period[7:1]};
	end
endmodule

// ### dv/speed_trip_relay_logic_bench.sv
`timescale 1ns/10ps
module speed_trip_relay_logic_bench;
	reg         ref_clk, nrst, clk_en, override_n, latch_rst_n;
	reg         bus_wr, bus_rd;
	reg  [3:0]  bus_addr;
	reg  [31:0] bus_wdata;
	reg  [7:0]  period;
	wire        pulse_in, relay_out, led_input, led_relay;
	wire [31:0] bus_rdata;
	integer     num_errors, n_tests, i;
	// ctrl, period, latch reset, override, relay
	reg  [27:0] rows [0:24] = '{
		28'h0000057, 28'h0000146, 28'h0002147, 28'h0002086,
		28'h0800086, 28'h0700087, 28'h07020C6, 28'h07020D7,
		28'h7000057, 28'h70000B7, 28'h70000D6, 28'h70020B7,
		28'h7002097, 28'h7002086, 28'h0006057, 28'h0006054,
		28'h0006057, 28'h0001057, 28'h0001147, 28'h0001053,
		28'h0001142, 28'h0003147, 28'h0003057, 28'h0003052,
		28'h0000142};

	speed_trip_relay #(.CLK_HZ(1000), .CYC_PER_MS(10)) i_dut (.ref_clk,
		.nrst, .clk_en, .pulse_in, .override_n, .latch_rst_n, .bus_addr,
		.bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .relay_out, .led_input,
		.led_relay);
	pulse_src i_src (.ref_clk, .period, .pulse(pulse_in));

	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		begin
			bus_addr <= a;
			bus_wdata <= d;
			bus_wr <= 1'b1;
			@(posedge ref_clk);
			bus_wr <= 1'b0;
			@(posedge ref_clk);
		end
	endtask
	task rd(input [3:0] a, input [31:0] e);
		begin
			bus_addr <= a;
			bus_rd <= 1'b1;
			@(posedge ref_clk);
			bus_rd <= 1'b0;
			@(negedge ref_clk);
			chk(bus_rdata, e);
			@(posedge ref_clk);
		end
	endtask
	task run(input [7:0] p, input e);
		begin
			period <= p;
			repeat (300) @(posedge ref_clk);
			@(negedge ref_clk);
			chk(relay_out, e);
			@(posedge ref_clk);
		end
	endtask
	task stop_test;
		begin
			$display("errors %0d of %0d checks", num_errors, n_tests);
			if (num_errors == 0 && n_tests > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors = num_errors + 1;
		stop_test;
	end
	initial begin
		{num_errors, n_tests} = 0;
		{nrst, bus_wr, bus_rd, bus_addr, bus_wdata} = 0;
		{clk_en, override_n, latch_rst_n} = 3'h7;
		period = 8'h0A;
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		// table of modes, thresholds and buttons
		for (i = 0; i < 25; i = i + 1) begin
			wr(4'h0, {16'h0000, rows[i][27:12]});
			latch_rst_n <= rows[i][2];
			override_n <= rows[i][1];
			run(rows[i][11:4], rows[i][0]);
		end
		// frozen clock enable holds the relay
		clk_en <= 1'b0;
		run(8'h05, 1'b0);
		clk_en <= 1'b1;
		run(8'h05, 1'b1);
		// reset mid run, then registers and inhibit
		period <= 8'h14;
		nrst <= 1'b0;
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		chk(relay_out, 1'b0);
		rd(4'h0, 32'h0);
		rd(4'h4, 32'h3E8);
		rd(4'h2, 32'h0);
		wr(4'h4, 32'hFFFFFFFF);
		rd(4'h4, 32'h3FFFF);
		wr(4'h4, 32'h3E8);
		wr(4'h0, 32'h4);
		run(8'h14, 1'b0);
		run(8'h05, 1'b0);
		run(8'h14, 1'b1);
		rd(4'h8, 32'hD);
		rd(4'hC, 32'h3);
		stop_test;
	end
endmodule

bind speed_trip_relay speed_trip_monitor i_mon (.ref_clk, .nrst, .clk_en,
	.pulse_in, .override_n, .bus_rd, .bus_rdata, .relay_out, .led_input,
	.led_relay);
